// ===== blend_pkg.sv
// Behaviour
// - operation codes 0..4 are sum, difference, reverse difference, minimum, maximum.
// - colour channels and alpha each take their own operation selection.
// - sum/differences use factor products; minimum/maximum compare raw source and destination.
// - with blending off the first source colour is written unchanged, except that sRGB targets re-encode its red, green, blue.
// - fixed-point targets clamp inputs and factors to [0,1] or [-1,1]; float none.
// - sRGB targets linearize destination red, green, blue before blending.
// - sRGB targets re-encode final red, green, blue before the write.
// - alpha is never converted; non-sRGB colour is written without conversion.
// - a slot marked unused performs no write.
// - target indices at or above the target count perform no write.
// - the reduced dual-source target limit is readable by software.
// - second blender input must be written and bound, else the result is undefined.
// - factor codes 0..18 are decoded, including saturate and second-source variants.
// - a four-component blend constant feeds the constant colour and alpha factors.
package blend_pkg;
   localparam int CW = 16;
   localparam int FRAC = 14;
   localparam int TW = 3;
   localparam logic signed [CW-1:0] ONE = 16'sh4000;
   localparam logic signed [CW-1:0] MONE = 16'shC000;
   typedef logic signed [CW-1:0] chan_t;
   typedef chan_t [3:0] color_t;
   typedef struct packed {
      color_t src0;
      color_t src1;
      color_t dst;
      logic [TW-1:0] target;
   } sample_t;
   typedef struct packed {
      color_t color;
      logic [TW-1:0] target;
      logic write;
   } result_t;
   typedef enum logic [2:0] {
      op_sum = 3'h0, op_difference = 3'h1, op_reverse_difference = 3'h2,
      op_minimum = 3'h3, op_maximum = 3'h4
   } op_t;
   typedef enum logic [1:0] {
      fmt_unorm = 2'h0, fmt_snorm = 2'h1, fmt_float = 2'h2, fmt_srgb = 2'h3
   } fmt_t;
   typedef enum logic [4:0] {
      factor_zero = 5'h00, factor_one = 5'h01, factor_src = 5'h02, factor_inv_src = 5'h03,
      factor_dst = 5'h04, factor_inv_dst = 5'h05, factor_src_alpha = 5'h06,
      factor_inv_src_alpha = 5'h07, factor_dst_alpha = 5'h08, factor_inv_dst_alpha = 5'h09,
      factor_const = 5'h0a, factor_inv_const = 5'h0b, factor_const_alpha = 5'h0c,
      factor_inv_const_alpha = 5'h0d, factor_saturate = 5'h0e,
      factor_second_source_color = 5'h0f, factor_inv_second_color = 5'h10,
      factor_second_source_alpha = 5'h11, factor_inv_second_alpha = 5'h12
   } blend_factor_select_t;
   // register offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] FACTOR_OFS = 8'h04;
   localparam logic [7:0] CONST_RG_OFS = 8'h08;
   localparam logic [7:0] CONST_BA_OFS = 8'h0c;
   localparam logic [7:0] LIMIT_OFS = 8'h10;
   localparam logic [7:0] LUT_OFS = 8'h14;
   localparam logic [7:0] STATUS_OFS = 8'h18;
   // control fields
   localparam int EN_POS = 0;
   localparam int FMT_POS = 1;
   localparam int OPC_POS = 3;
   localparam int OPA_POS = 6;
   localparam int CNT_POS = 9;
   localparam int UNUSED_POS = 13;
   // factor fields: src colour, dst colour, src alpha, dst alpha
   localparam int FSC_POS = 0;
   localparam int FDC_POS = 5;
   localparam int FSA_POS = 10;
   localparam int FDA_POS = 15;
   // table load fields
   localparam int LUT_ADDR_POS = 16;
   localparam int LUT_SEL_POS = 24;
   // reset values
   localparam logic [3:0] CNT_RST = 4'h8;
   localparam logic [19:0] FACTOR_RST = 20'h0_8421;
endpackage

// ===== srgb_table.sv
`timescale 1ns/100ps
`default_nettype none
module srgb_table #(
   parameter int AW = 8,
   parameter int DW = 16,
   parameter int NRD = 3
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [DW-1:0] wr_data,
   input wire logic rd_en,
   input wire logic [NRD*AW-1:0] rd_addr,
   output logic [NRD*DW-1:0] rd_data
);
   // contents are loaded by software; no reset on the array itself
   logic [DW-1:0] mem [2**AW];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data <= '0;
      end else if (rd_en) begin
         for (int i = 0; i < NRD; i++) begin
            rd_data[i*DW +: DW] <= mem[rd_addr[i*AW +: AW]];
         end
      end
   end
endmodule
`default_nettype wire

// ===== color_blend_datapath.sv
`timescale 1ns/100ps
`default_nettype none
module color_blend_datapath #(
   parameter int TARGETS = 8,
   parameter logic [3:0] MAX_DUAL = 4'h1,
   parameter int LUT_AW = 8
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] addr,
   input wire logic [31:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [31:0] rd_data,
   input wire logic in_valid,
   output logic in_ready,
   input wire blend_pkg::sample_t in_sample,
   output logic out_valid,
   input wire logic out_ready,
   output blend_pkg::result_t out_result
);
   localparam int CW = blend_pkg::CW;

   ////////////////////////////////////////////////////////////////////////////
   // arithmetic helpers

   function automatic blend_pkg::chan_t sat(logic signed [CW+1:0] v);
      if (v > CW'(18'sd32767)) return 16'sh7fff;
      if (v < -18'sd32768) return 16'sh8000;
      return v[CW-1:0];
   endfunction

   function automatic blend_pkg::chan_t inv(blend_pkg::chan_t x);
      return sat((CW+2)'(blend_pkg::ONE) - (CW+2)'(x));
   endfunction

   function automatic blend_pkg::chan_t clampc(blend_pkg::chan_t v, blend_pkg::fmt_t f);
      case (f)
         blend_pkg::fmt_unorm, blend_pkg::fmt_srgb: begin
            return (v < 0) ? 16'sh0000 : (v > blend_pkg::ONE) ? blend_pkg::ONE : v;
         end
         blend_pkg::fmt_snorm: begin
            return (v < blend_pkg::MONE) ? blend_pkg::MONE : (v > blend_pkg::ONE) ? blend_pkg::ONE : v;
         end
         default: return v;
      endcase
   endfunction

   function automatic logic signed [CW+1:0] mulq(blend_pkg::chan_t a, blend_pkg::chan_t b);
      logic signed [2*CW-1:0] p;
      p = a * b;
      return p[blend_pkg::FRAC+CW+1:blend_pkg::FRAC];
   endfunction

   // table index of a [0,1] value; 1.0 lands on the last entry
   function automatic logic [LUT_AW-1:0] lut_idx(blend_pkg::chan_t v);
      if (v >= blend_pkg::ONE) return '1;
      if (v <= 0) return '0;
      return v[blend_pkg::FRAC-1 -: LUT_AW];
   endfunction

   function automatic blend_pkg::chan_t factor(logic [4:0] code, blend_pkg::color_t s0,
      blend_pkg::color_t s1, blend_pkg::color_t d, blend_pkg::color_t c, int k);
      blend_pkg::chan_t m;
      m = (s0[3] < inv(d[3])) ? s0[3] : inv(d[3]);
      case (code)
         blend_pkg::factor_one: return blend_pkg::ONE;
         blend_pkg::factor_src: return s0[k];
         blend_pkg::factor_inv_src: return inv(s0[k]);
         blend_pkg::factor_dst: return d[k];
         blend_pkg::factor_inv_dst: return inv(d[k]);
         blend_pkg::factor_src_alpha: return s0[3];
         blend_pkg::factor_inv_src_alpha: return inv(s0[3]);
         blend_pkg::factor_dst_alpha: return d[3];
         blend_pkg::factor_inv_dst_alpha: return inv(d[3]);
         blend_pkg::factor_const: return c[k];
         blend_pkg::factor_inv_const: return inv(c[k]);
         blend_pkg::factor_const_alpha: return c[3];
         blend_pkg::factor_inv_const_alpha: return inv(c[3]);
         blend_pkg::factor_saturate: return (k == 3) ? blend_pkg::ONE : m;
         blend_pkg::factor_second_source_color: return s1[k];
         blend_pkg::factor_inv_second_color: return inv(s1[k]);
         blend_pkg::factor_second_source_alpha: return s1[3];
         blend_pkg::factor_inv_second_alpha: return inv(s1[3]);
         default: return 16'sh0000;
      endcase
   endfunction

   function automatic blend_pkg::chan_t blend_op(logic [2:0] op, blend_pkg::chan_t s,
      blend_pkg::chan_t sf, blend_pkg::chan_t d, blend_pkg::chan_t df);
      case (op)
         blend_pkg::op_sum: return sat(mulq(s, sf) + mulq(d, df));
         blend_pkg::op_difference: return sat(mulq(s, sf) - mulq(d, df));
         blend_pkg::op_reverse_difference: return sat(mulq(d, df) - mulq(s, sf));
         blend_pkg::op_minimum: return (s < d) ? s : d;
         blend_pkg::op_maximum: return (s > d) ? s : d;
         default: return s;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // register file

   logic blend_en_q;
   blend_pkg::fmt_t fmt_q;
   logic [2:0] op_rgb_q;
   logic [2:0] op_a_q;
   logic [3:0] tcount_q;
   logic [7:0] unused_q;
   logic [19:0] fac_q;
   blend_pkg::color_t const_q;
   logic [15:0] wr_cnt_q;
   logic [15:0] sup_cnt_q;
   logic lut_we;
   logic lut_sel;

   assign lut_sel = wr_data[blend_pkg::LUT_SEL_POS];
   assign lut_we = wr_en && addr == blend_pkg::LUT_OFS;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         blend_en_q <= 1'b0;
         fmt_q <= blend_pkg::fmt_unorm;
         op_rgb_q <= 3'h0;
         op_a_q <= 3'h0;
         tcount_q <= blend_pkg::CNT_RST;
         unused_q <= 8'h00;
      end else if (wr_en && addr == blend_pkg::CTRL_OFS) begin
         blend_en_q <= wr_data[blend_pkg::EN_POS];
         fmt_q <= blend_pkg::fmt_t'(wr_data[blend_pkg::FMT_POS +: 2]);
         op_rgb_q <= wr_data[blend_pkg::OPC_POS +: 3];
         op_a_q <= wr_data[blend_pkg::OPA_POS +: 3];
         tcount_q <= wr_data[blend_pkg::CNT_POS +: 4];
         unused_q <= wr_data[blend_pkg::UNUSED_POS +: 8];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fac_q <= blend_pkg::FACTOR_RST;
         const_q <= '0;
      end else if (wr_en) begin
         if (addr == blend_pkg::FACTOR_OFS) begin
            fac_q <= wr_data[19:0];
         end
         if (addr == blend_pkg::CONST_RG_OFS) begin
            const_q[1:0] <= wr_data;
         end
         if (addr == blend_pkg::CONST_BA_OFS) begin
            const_q[3:2] <= wr_data;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data <= 32'h0000_0000;
      end else if (rd_en) begin
         case (addr)
            blend_pkg::CTRL_OFS: begin
               rd_data <= {11'h000, unused_q, tcount_q, op_a_q, op_rgb_q, fmt_q, blend_en_q};
            end
            blend_pkg::FACTOR_OFS: rd_data <= {12'h000, fac_q};
            blend_pkg::CONST_RG_OFS: rd_data <= const_q[1:0];
            blend_pkg::CONST_BA_OFS: rd_data <= const_q[3:2];
            blend_pkg::LIMIT_OFS: rd_data <= {28'h000_0000, MAX_DUAL};
            blend_pkg::STATUS_OFS: rd_data <= {sup_cnt_q, wr_cnt_q};
            default: rd_data <= 32'h0000_0000;
         endcase
      end else begin
         rd_data <= 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pipeline: accept -> blend -> encode/out, all stages move together

   logic adv;
   logic va_q;
   logic vb_q;
   blend_pkg::sample_t a_q;
   blend_pkg::result_t b_q;
   logic [3*CW-1:0] dec_data;
   logic [3*CW-1:0] enc_data;
   logic [3*LUT_AW-1:0] dec_addr;
   logic [3*LUT_AW-1:0] enc_addr;
   blend_pkg::color_t s0c, s1c, dc, cc, res;
   logic wr_ok;

   // a single stall term keeps the lookup registers aligned with their stage
   assign adv = !out_valid || out_ready;
   assign in_ready = adv;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         va_q <= 1'b0;
         vb_q <= 1'b0;
         out_valid <= 1'b0;
         a_q <= '0;
      end else if (adv) begin
         va_q <= in_valid;
         vb_q <= va_q;
         out_valid <= vb_q;
         if (in_valid) begin
            a_q <= in_sample;
         end
      end
   end

   always_comb begin
      for (int k = 0; k < 3; k++) begin
         dec_addr[k*LUT_AW +: LUT_AW] = lut_idx(in_sample.dst[k]);
         enc_addr[k*LUT_AW +: LUT_AW] = lut_idx(res[k]);
      end
   end

   srgb_table #(.AW(LUT_AW), .DW(CW), .NRD(3)) decode_table (
      .clk(clk),
      .rst_b(rst_b),
      .wr_en(lut_we && !lut_sel),
      .wr_addr(wr_data[blend_pkg::LUT_ADDR_POS +: LUT_AW]),
      .wr_data(wr_data[CW-1:0]),
      .rd_en(adv),
      .rd_addr(dec_addr),
      .rd_data(dec_data)
   );

   srgb_table #(.AW(LUT_AW), .DW(CW), .NRD(3)) encode_table (
      .clk(clk),
      .rst_b(rst_b),
      .wr_en(lut_we && lut_sel),
      .wr_addr(wr_data[blend_pkg::LUT_ADDR_POS +: LUT_AW]),
      .wr_data(wr_data[CW-1:0]),
      .rd_en(adv),
      .rd_addr(enc_addr),
      .rd_data(enc_data)
   );

   always_comb begin
      for (int k = 0; k < 4; k++) begin
         s0c[k] = clampc(a_q.src0[k], fmt_q);
         s1c[k] = clampc(a_q.src1[k], fmt_q);
         cc[k] = clampc(const_q[k], fmt_q);
         if (fmt_q == blend_pkg::fmt_srgb && k < 3) begin
            dc[k] = dec_data[k*CW +: CW];
         end else begin
            dc[k] = clampc(a_q.dst[k], fmt_q);
         end
      end
      for (int k = 0; k < 4; k++) begin
         if (!blend_en_q) begin
            res[k] = a_q.src0[k];
         end else if (k == 3) begin
            res[k] = clampc(blend_op(op_a_q, s0c[k],
               clampc(factor(fac_q[blend_pkg::FSA_POS +: 5], s0c, s1c, dc, cc, k), fmt_q), dc[k],
               clampc(factor(fac_q[blend_pkg::FDA_POS +: 5], s0c, s1c, dc, cc, k), fmt_q)), fmt_q);
         end else begin
            res[k] = clampc(blend_op(op_rgb_q, s0c[k],
               clampc(factor(fac_q[blend_pkg::FSC_POS +: 5], s0c, s1c, dc, cc, k), fmt_q), dc[k],
               clampc(factor(fac_q[blend_pkg::FDC_POS +: 5], s0c, s1c, dc, cc, k), fmt_q)), fmt_q);
         end
      end
   end

   assign wr_ok = !unused_q[a_q.target] && {1'b0, a_q.target} < tcount_q;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         b_q <= '0;
      end else if (adv && va_q) begin
         b_q.color <= res;
         b_q.target <= a_q.target;
         b_q.write <= wr_ok;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         out_result <= '0;
      end else if (adv && vb_q) begin
         out_result.target <= b_q.target;
         out_result.write <= b_q.write;
         out_result.color[3] <= b_q.color[3];
         for (int k = 0; k < 3; k++) begin
            if (fmt_q == blend_pkg::fmt_srgb) begin
               out_result.color[k] <= enc_data[k*CW +: CW];
            end else begin
               out_result.color[k] <= b_q.color[k];
            end
         end
      end
   end

   // counters saturate rather than wrap so a long run never looks idle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_cnt_q <= 16'h0000;
         sup_cnt_q <= 16'h0000;
      end else if (out_valid && out_ready) begin
         if (out_result.write && wr_cnt_q != 16'hffff) begin
            wr_cnt_q <= wr_cnt_q + 16'h0001;
         end
         if (!out_result.write && sup_cnt_q != 16'hffff) begin
            sup_cnt_q <= sup_cnt_q + 16'h0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   AST_ACCEPT: assert property (@(posedge clk) disable iff (!rst_b)
      in_valid && in_ready |=> va_q && a_q.target == $past(in_sample.target))
      else $error("accepted sample not captured");
   AST_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
      out_valid && !out_ready |=> out_valid && $stable(out_result))
      else $error("output changed under stall");
   AST_BYPASS: assert property (@(posedge clk) disable iff (!rst_b)
      va_q && adv && !blend_en_q |=> b_q.color[3] == $past(a_q.src0[3]))
      else $error("disabled blend altered source");
   AST_UNUSED: assert property (@(posedge clk) disable iff (!rst_b)
      va_q && adv && unused_q[a_q.target] |=> !b_q.write)
      else $error("write through unused slot");
   AST_COUNT: assert property (@(posedge clk) disable iff (!rst_b)
      va_q && adv && {1'b0, a_q.target} >= tcount_q |=> !b_q.write)
      else $error("write beyond target count");
   AST_MIN: assert property (@(posedge clk) disable iff (!rst_b)
      va_q && adv && blend_en_q && fmt_q == blend_pkg::fmt_float && op_a_q == blend_pkg::op_minimum
      |=> b_q.color[3] <= $past(a_q.src0[3]) && b_q.color[3] <= $past(a_q.dst[3]))
      else $error("minimum wrong");
   AST_MAX: assert property (@(posedge clk) disable iff (!rst_b)
      va_q && adv && blend_en_q && fmt_q == blend_pkg::fmt_float && op_a_q == blend_pkg::op_maximum
      |=> b_q.color[3] >= $past(a_q.src0[3]) && b_q.color[3] >= $past(a_q.dst[3]))
      else $error("maximum wrong");
   AST_UNORM: assert property (@(posedge clk) disable iff (!rst_b)
      va_q && adv && blend_en_q && fmt_q == blend_pkg::fmt_unorm
      |=> b_q.color[3] >= 0 && b_q.color[3] <= blend_pkg::ONE)
      else $error("unorm result out of range");
   AST_SNORM: assert property (@(posedge clk) disable iff (!rst_b)
      va_q && adv && blend_en_q && fmt_q == blend_pkg::fmt_snorm
      |=> b_q.color[0] >= blend_pkg::MONE && b_q.color[0] <= blend_pkg::ONE)
      else $error("snorm result out of range");
   AST_ALPHA: assert property (@(posedge clk) disable iff (!rst_b)
      vb_q && adv |=> out_result.color[3] == $past(b_q.color[3]))
      else $error("alpha was converted");
   AST_LIMIT: assert property (@(posedge clk) disable iff (!rst_b)
      rd_en && addr == blend_pkg::LIMIT_OFS |=> rd_data == {28'h000_0000, MAX_DUAL})
      else $error("dual-source limit misread");
   AST_CONST: assert property (@(posedge clk) disable iff (!rst_b)
      wr_en && addr == blend_pkg::CONST_RG_OFS |=> const_q[0] == $past(wr_data[15:0]))
      else $error("constant not stored");
endmodule
`default_nettype wire

// ===== blend_sink.sv
`timescale 1ns/100ps
`default_nettype none
module blend_sink (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic stall_en,
   input wire logic out_valid,
   input wire blend_pkg::result_t out_result,
   output logic out_ready
);
   // render target store: last colour written per target
   blend_pkg::color_t mem_q [8];
   logic rdy_q = 1'b1;
   assign out_ready = rdy_q;
   ////////////////////////////////////////////////////////////////
   // back-pressure is random once enabled, so prompt and slow takes both occur
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdy_q <= 1'b1;
      end else begin
         rdy_q <= !stall_en || ($urandom_range(0, 2) != 0);
         if (out_valid && out_ready && out_result.write) begin
            mem_q[out_result.target] <= out_result.color;
         end
      end
   end
endmodule
`default_nettype wire

// ===== color_blend_datapath_bench.sv
`timescale 1ns/100ps
`default_nettype none
module color_blend_datapath_bench;
   localparam logic [3:0] DUAL = 4'h3;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wr_data = 32'h0000_0000;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [31:0] rd_data;
   logic in_valid = 1'b0;
   logic in_ready;
   blend_pkg::sample_t in_sample = '0;
   logic out_valid;
   logic out_ready;
   blend_pkg::result_t out_result;
   logic stall_en = 1'b0;
   logic rd_q = 1'b0;
   int fail_count = 0;
   int check_count = 0;
   logic [31:0] rd_exp [$];
   blend_pkg::result_t res_exp [$];
   int fr [19] = '{0, 16'h4000, 16'h2000, 16'h2000, 16'h0800, 16'h3800, 16'h3000, 16'h1000, 16'h1000, 16'h3000,
      16'h1800, 16'h2800, 16'h2800, 16'h1800, 16'h3000, 16'h0c00, 16'h3400, 16'h0400, 16'h3c00};
   int fa [19] = '{0, 16'h4000, 16'h3000, 16'h1000, 16'h1000, 16'h3000, 16'h3000, 16'h1000, 16'h1000, 16'h3000,
      16'h2800, 16'h1800, 16'h2800, 16'h1800, 16'h4000, 16'h0400, 16'h3c00, 16'h0400, 16'h3c00};
   always #4 clk = ~clk;
   color_blend_datapath #(.MAX_DUAL(DUAL)) dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .in_valid(in_valid), .in_ready(in_ready),
      .in_sample(in_sample), .out_valid(out_valid), .out_ready(out_ready), .out_result(out_result));
   blend_sink sink (.clk(clk), .rst_b(rst_b), .stall_en(stall_en), .out_valid(out_valid),
      .out_result(out_result), .out_ready(out_ready));
   ////////////////////////////////////////////////////////////////
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic cmp_word(string name, logic [31:0] exp, logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic cmp_res(blend_pkg::result_t exp, blend_pkg::result_t got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error out_result expected %h seen %h", exp, got);
      end
   endtask
   task automatic give_up();
      fail_count++;
      $display("Error wait expected done seen timeout");
      close_out();
   endtask
   ////////////////////////////////////////////////////////////////
   // read data stand only in the cycle after the strobe, zero otherwise
   always @(posedge clk) begin
      rd_q <= rd_en;
      if (rd_q && rd_exp.size() > 0) begin
         cmp_word("rd_data", rd_exp.pop_front(), rd_data);
      end else if (rst_b) begin
         cmp_word("rd_data idle", 32'h0000_0000, rd_data);
      end
      if (out_valid === 1'b1 && out_ready === 1'b1) begin
         if (res_exp.size() > 0) begin
            cmp_res(res_exp.pop_front(), out_result);
         end else begin
            give_up();
         end
      end
   end
   ////////////////////////////////////////////////////////////////
   task automatic reg_wr(logic [7:0] a, logic [31:0] d);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      @(posedge clk);
   endtask
   task automatic reg_rd(logic [7:0] a, logic [31:0] e);
      rd_exp.push_back(e);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      @(posedge clk);
   endtask
   task automatic send(blend_pkg::color_t s0, blend_pkg::color_t s1, blend_pkg::color_t d, logic [2:0] t,
      blend_pkg::color_t e, logic w);
      int n;
      res_exp.push_back('{color: e, target: t, write: w});
      in_sample <= '{src0: s0, src1: s1, dst: d, target: t};
      in_valid <= 1'b1;
      n = 0;
      @(negedge clk);
      while (in_ready !== 1'b1) begin
         n++;
         if (n > 200) give_up();
         @(negedge clk);
      end
      @(posedge clk);
   endtask
   // configuration is live, so every change waits for the pipe to empty
   task automatic drain(string name);
      int n;
      in_valid <= 1'b0;
      n = 0;
      while (res_exp.size() != 0) begin
         n++;
         if (n > 300) give_up();
         @(posedge clk);
      end
      repeat (2) @(posedge clk);
      $display("test %s done", name);
   endtask
   function automatic blend_pkg::color_t c4(logic [15:0] a, logic [15:0] v);
      return {a, v, v, v};
   endfunction
   function automatic logic [31:0] ctrl(int en, int fmt, int opc, int opa, int cnt, int unused);
      return (en << blend_pkg::EN_POS) | (fmt << blend_pkg::FMT_POS) | (opc << blend_pkg::OPC_POS)
         | (opa << blend_pkg::OPA_POS) | (cnt << blend_pkg::CNT_POS) | (unused << blend_pkg::UNUSED_POS);
   endfunction
   function automatic logic [31:0] fac(int sc, int dc, int sa, int da);
      return (sc << blend_pkg::FSC_POS) | (dc << blend_pkg::FDC_POS) | (sa << blend_pkg::FSA_POS)
         | (da << blend_pkg::FDA_POS);
   endfunction
   // unsigned normalised result: sum/differences on products, minimum/maximum on raw values, clamped again to [0,1]
   function automatic logic [15:0] mix(int op, int s, int d, int fs, int fd);
      int a;
      int b;
      int r;
      a = (s * fs) >>> 14;
      b = (d * fd) >>> 14;
      case (op)
         0: r = a + b;
         1: r = a - b;
         2: r = b - a;
         3: r = (s < d) ? s : d;
         default: r = (s > d) ? s : d;
      endcase
      r = (r < 0) ? 0 : ((r > 16'h4000) ? 16'h4000 : r);
      return r[15:0];
   endfunction
   ////////////////////////////////////////////////////////////////
   initial begin
      blend_pkg::color_t s0;
      void'($urandom(32'ha28e));
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      stall_en <= 1'b1;
      reg_rd(blend_pkg::CTRL_OFS, 32'h0000_1000);
      reg_rd(blend_pkg::FACTOR_OFS, {12'h000, blend_pkg::FACTOR_RST});
      reg_wr(blend_pkg::LIMIT_OFS, 32'hffff_ffff);
      reg_rd(blend_pkg::LIMIT_OFS, {28'h000_0000, DUAL});
      reg_rd(8'h1c, 32'h0000_0000);
      $display("test registers done");
      for (int i = 0; i < 6; i++) begin
         s0 = {$urandom, $urandom};
         send(s0, c4(16'h0000, 16'h0000), c4(16'h1234, 16'h0567), 3'(i), s0, 1'b1);
      end
      drain("disabled");
      reg_wr(blend_pkg::FACTOR_OFS, fac(1, 1, 1, 1));
      for (int op = 0; op < 5; op++) begin
         // colour minimum and maximum run on a float target so the unclamped compare path is exercised
         reg_wr(blend_pkg::CTRL_OFS, ctrl(1, op > 2 ? 2 : 0, op, (op + 1) % 5, 8, 0));
         send(c4(16'h3000, 16'h3000), c4(16'h0000, 16'h0000), c4(16'h1000, 16'h1000), 3'h0,
            c4(mix((op + 1) % 5, 16'h3000, 16'h1000, 16'h4000, 16'h4000),
            mix(op, 16'h3000, 16'h1000, 16'h4000, 16'h4000)), 1'b1);
         drain("operation");
      end
      // constant changes only while idle
      reg_wr(blend_pkg::CONST_RG_OFS, 32'h1800_1800);
      reg_wr(blend_pkg::CONST_BA_OFS, 32'h2800_1800);
      reg_wr(blend_pkg::CTRL_OFS, ctrl(1, 0, 0, 0, 8, 0));
      // second-source codes are used with the dual-source capability taken as enabled
      for (int f = 0; f < 19; f++) begin
         reg_wr(blend_pkg::FACTOR_OFS, fac(f, 0, f, 0));
         send(c4(16'h3000, 16'h2000), c4(16'h0400, 16'h0c00), c4(16'h1000, 16'h0800), 3'h0,
            c4(mix(0, 16'h3000, 0, fa[f], 0), mix(0, 16'h2000, 0, fr[f], 0)), 1'b1);
         drain("factor");
      end
      reg_wr(blend_pkg::FACTOR_OFS, fac(1, 0, 1, 0));
      for (int fm = 0; fm < 3; fm++) begin
         // float alpha takes minimum against a zero destination, which leaves the source unchanged
         reg_wr(blend_pkg::CTRL_OFS, ctrl(1, fm, 0, fm == 2 ? 3 : 0, 8, 0));
         send(c4(fm == 0 ? 16'hc000 : 16'ha000, 16'h5000), c4(16'h0000, 16'h0000), c4(16'h0000, 16'h0000), 3'h0,
            c4(fm == 0 ? 16'h0000 : (fm == 1 ? 16'hc000 : 16'ha000), fm == 2 ? 16'h5000 : 16'h4000), 1'b1);
         drain("clamp");
      end
      reg_wr(blend_pkg::LUT_OFS, 32'h0080_1000);
      reg_wr(blend_pkg::LUT_OFS, 32'h0140_3000);
      reg_wr(blend_pkg::FACTOR_OFS, fac(0, 1, 0, 1));
      reg_wr(blend_pkg::CTRL_OFS, ctrl(1, 3, 0, 0, 8, 0));
      send(c4(16'h1000, 16'h1000), c4(16'h0000, 16'h0000), c4(16'h2000, 16'h2000), 3'h1,
         c4(16'h2000, 16'h3000), 1'b1);
      drain("srgb");
      reg_wr(blend_pkg::CTRL_OFS, ctrl(1, 0, 0, 0, 8, 0));
      send(c4(16'h1000, 16'h1000), c4(16'h0000, 16'h0000), c4(16'h2000, 16'h2000), 3'h1,
         c4(16'h2000, 16'h2000), 1'b1);
      drain("linear");
      reg_wr(blend_pkg::CTRL_OFS, ctrl(0, 0, 0, 0, 3, 8'h02));
      for (int t = 0; t < 8; t++) begin
         s0 = {$urandom, $urandom};
         send(s0, c4(16'h0000, 16'h0000), c4(16'h0000, 16'h0000), 3'(t), s0, t < 3 && t != 1);
      end
      drain("targets");
      // 37 results written and 6 suppressed over the whole run
      reg_rd(blend_pkg::STATUS_OFS, 32'h0006_0025);
      repeat (2) @(posedge clk);
      $display("test status done");
      close_out();
   end
endmodule
`default_nettype wire
